/* adc_measurement_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"

module adc_measurement_sequencer #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Converter and input multiplexer
    output logic [3:0] o_mux_channel,
    output logic o_single_channel_select_start,
    output logic [4:0] o_attenuator_bypass_all_bypass,
    input wire logic i_single_channel_select_done,
    input wire logic [9:0] i_single_channel_select_code,
    // Finished measurements
    output logic o_result_valid,
    output logic [3:0] o_result_channel,
    output logic [9:0] o_result_code
);
    logic rst_meta_b_ff;
    logic rst_b_ff;
    logic tick;
    logic [7:0] cfg6_ff;
    logic [7:0] cfg2_ff;
    logic [7:0] cfg4_ff;
    logic [7:0] fan1_ff;
    logic [9:0] val_ff [0:6];
    logic [6:0] lock_ff;
    adc_seq_pkg::seq_state_t state_ff;
    adc_seq_pkg::seq_state_t nxt_state;
    adc_seq_pkg::chan_t chan_ff;
    adc_seq_pkg::chan_t nxt_chan;
    logic [6:0] slot_cnt_ff;
    logic [6:0] nxt_slot_cnt;
    logic [3:0] single_channel_select_cnt_ff;
    logic [3:0] nxt_single_channel_select_cnt;
    logic [11:0] frame_cnt_ff;
    logic [11:0] nxt_frame_cnt;
    logic single_channel_select_start_ff;
    logic [3:0] mux_chan_ff;
    logic [4:0] attenuator_bypass_all_ff;
    logic result_valid_ff;
    logic [3:0] result_chan_ff;
    logic [9:0] result_code_ff;
    logic [7:0] rdata_ff;
    logic [7:0] rd_mux;

    // Reset release through two flops
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_b_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end
        else
        begin
            rst_meta_b_ff <= 1'b1;
            rst_b_ff <= rst_meta_b_ff;
        end
    end

    // A 0.1 ms enable paces every slot and the pass timer
    tick_gen #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .i_clock(i_clock),
        .i_rst_b(rst_b_ff),
        .o_tick(tick)
    );

    accum_if acc ();

    avg_accum #(
        .SHIFT(`AVG_SHIFT)
    ) u_acc (
        .i_clock(i_clock),
        .i_rst_b(rst_b_ff),
        .bus(acc.accum)
    );

    function automatic logic [6:0] slot_len(input logic [3:0] c);
        case (c)
            `CH_REMOTE1, `CH_REMOTE2: slot_len = 7'(`REMOTE_TICKS);
            `CH_LOCAL: slot_len = 7'(`LOCAL_TICKS);
            default: slot_len = 7'(`VOLT_TICKS);
        endcase
    endfunction

    // Voltage channels own a value register; temperatures do not
    function automatic logic [6:0] slot_sel(input logic [3:0] c);
        case (c)
            `CH_2V5: slot_sel = 7'h01;
            `CH_CORE: slot_sel = 7'h02;
            `CH_SUPPLY: slot_sel = 7'h04;
            `CH_5V: slot_sel = 7'h08;
            `CH_12V: slot_sel = 7'h10;
            `CH_TERM: slot_sel = 7'h20;
            `CH_CURRENT: slot_sel = 7'h40;
            default: slot_sel = 7'h00;
        endcase
    endfunction

    // Register decode
    wire hit_cfg6 = (i_reg_addr == `ADDR_CONFIG_SIX);
    wire hit_cfg2 = (i_reg_addr == `ADDR_CONFIG_TWO);
    wire hit_cfg4 = (i_reg_addr == `ADDR_CONFIG_FOUR);
    wire hit_fan1 = (i_reg_addr == `ADDR_FAN1_MIN_HIGH);
    wire rd_ext_a = i_reg_rd && (i_reg_addr == `ADDR_EXT_RES_A);
    wire rd_ext_b = i_reg_rd && (i_reg_addr == `ADDR_EXT_RES_B);
    wire rd_ext_c = i_reg_rd && (i_reg_addr == `ADDR_EXT_RES_C);
    wire [6:0] rd_val = {7{i_reg_rd}} & {
        i_reg_addr == `ADDR_CURRENT_MONITOR,
        i_reg_addr == `ADDR_TERMINATION,
        i_reg_addr == `ADDR_RAIL_12V,
        i_reg_addr == `ADDR_RAIL_5V,
        i_reg_addr == `ADDR_SUPPLY_VOLTAGE,
        i_reg_addr == `ADDR_CORE_VOLTAGE,
        i_reg_addr == `ADDR_RAIL_2V5};
    wire [6:0] lock_set = ({7{rd_ext_a}} & 7'h0F) |
        ({7{rd_ext_b}} & 7'h30) | ({7{rd_ext_c}} & 7'h40);

    // Control fields
    wire slow_cycle = cfg6_ff[`BIT_SLOW_CYCLE];
    wire avg_off = cfg2_ff[`BIT_AVG_DISABLE];
    wire attenuator_bypass_all_all = cfg2_ff[`BIT_ATTENUATOR_BYPASS_ALL_ALL];
    wire single = cfg2_ff[`BIT_SINGLE];
    wire [3:0] sel_code = fan1_ff[7:4];
    wire [3:0] sel_chan = (sel_code > `CH_LAST) ? `CH_2V5 : sel_code;
    wire [4:0] attenuator_bypass_all_next = {cfg4_ff[`BIT_BYP_12V], cfg4_ff[`BIT_BYP_5V],
        1'b0, cfg4_ff[`BIT_BYP_CORE], cfg4_ff[`BIT_BYP_2V5]} |
        {5{attenuator_bypass_all_all}};
    wire [11:0] frame_target = slow_cycle ?
        12'(`CYCLE_SLOW_TICKS) : 12'(`CYCLE_DEFAULT_TICKS);

    // Sequencer decode
    wire in_slot = (state_ff == adc_seq_pkg::ST_SLOT);
    wire slot_end = in_slot && tick && (slot_cnt_ff == 7'h01);
    wire single_channel_select_last = avg_off ||
        (single_channel_select_cnt_ff == 4'(`AVG_COUNT - 1));
    wire store = slot_end && single_channel_select_last;
    wire wrap = !single && (chan_ff == `CH_LAST);
    wire [3:0] next_chan = single ? sel_chan :
        (chan_ff == `CH_LAST) ? `CH_2V5 : chan_ff + 4'h1;
    wire hold_done = avg_off || single ||
        (frame_cnt_ff >= frame_target);
    wire [6:0] val_we = {7{store}} & slot_sel(chan_ff) & ~lock_ff;

    // Raw 10-bit codes go straight into the averager
    assign acc.clear = store;
    assign acc.add = in_slot && i_single_channel_select_done;
    assign acc.code = i_single_channel_select_code;
    assign acc.avg_off = avg_off;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_slot_cnt = slot_cnt_ff;
        nxt_single_channel_select_cnt = single_channel_select_cnt_ff;
        nxt_frame_cnt = frame_cnt_ff;
        if (tick && (frame_cnt_ff != 12'hFFF))
            nxt_frame_cnt = frame_cnt_ff + 12'h001;
        case (state_ff)
            adc_seq_pkg::ST_START:
            begin
                nxt_slot_cnt = slot_len(chan_ff);
                nxt_state = adc_seq_pkg::ST_SLOT;
            end
            adc_seq_pkg::ST_SLOT:
            begin
                if (tick)
                    nxt_slot_cnt = slot_cnt_ff - 7'h01;
                if (slot_end)
                begin
                    nxt_single_channel_select_cnt = single_channel_select_last ? 4'h0 : single_channel_select_cnt_ff + 4'h1;
                    nxt_state = adc_seq_pkg::ST_START;
                    if (single_channel_select_last)
                    begin
                        nxt_chan = next_chan;
                        if (wrap)
                            nxt_state = adc_seq_pkg::ST_HOLD;
                    end
                end
            end
            adc_seq_pkg::ST_HOLD:
            begin
                if (hold_done)
                begin
                    nxt_state = adc_seq_pkg::ST_START;
                    nxt_chan = single ? sel_chan : `CH_2V5;
                    nxt_frame_cnt = 12'h000;
                end
            end
            default:
                nxt_state = adc_seq_pkg::ST_START;
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            state_ff <= adc_seq_pkg::ST_START;
            chan_ff <= `CH_2V5;
            slot_cnt_ff <= 7'h00;
            single_channel_select_cnt_ff <= 4'h0;
            frame_cnt_ff <= 12'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            slot_cnt_ff <= nxt_slot_cnt;
            single_channel_select_cnt_ff <= nxt_single_channel_select_cnt;
            frame_cnt_ff <= nxt_frame_cnt;
        end
    end

    // Software registers; the fan byte keeps all eight bits
    always_ff @(posedge i_clock or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            cfg6_ff <= `CFG_RESET;
            cfg2_ff <= `CFG_RESET;
            cfg4_ff <= `CFG_RESET;
            fan1_ff <= `FAN1_RESET;
        end
        else if (i_reg_wr)
        begin
            if (hit_cfg6)
                cfg6_ff <= i_reg_wdata;
            if (hit_cfg2)
                cfg2_ff <= i_reg_wdata;
            if (hit_cfg4)
                cfg4_ff <= i_reg_wdata;
            if (hit_fan1)
                fan1_ff <= i_reg_wdata;
        end
    end

    // Lock survives until the value byte itself is read; updates that
    // arrive meanwhile are dropped, not queued
    always_ff @(posedge i_clock or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            lock_ff <= 7'h00;
        else
            lock_ff <= (lock_ff & ~rd_val) | lock_set;
    end

    for (genvar g = 0; g < 7; g++)
    begin : g_val
        always_ff @(posedge i_clock or negedge rst_b_ff)
        begin
            if (!rst_b_ff)
                val_ff[g] <= 10'h000;
            else if (val_we[g])
                val_ff[g] <= acc.result;
        end
    end

    always_comb
    begin
        rd_mux = 8'h00;
        case (i_reg_addr)
            `ADDR_CONFIG_SIX: rd_mux = cfg6_ff;
            `ADDR_CONFIG_TWO: rd_mux = cfg2_ff;
            `ADDR_CONFIG_FOUR: rd_mux = cfg4_ff;
            `ADDR_FAN1_MIN_HIGH: rd_mux = fan1_ff;
            `ADDR_RAIL_2V5: rd_mux = val_ff[0][9:2];
            `ADDR_CORE_VOLTAGE: rd_mux = val_ff[1][9:2];
            `ADDR_SUPPLY_VOLTAGE: rd_mux = val_ff[2][9:2];
            `ADDR_RAIL_5V: rd_mux = val_ff[3][9:2];
            `ADDR_RAIL_12V: rd_mux = val_ff[4][9:2];
            `ADDR_TERMINATION: rd_mux = val_ff[5][9:2];
            `ADDR_CURRENT_MONITOR: rd_mux = val_ff[6][9:2];
            `ADDR_EXT_RES_A: rd_mux = {val_ff[3][1:0], val_ff[2][1:0],
                val_ff[1][1:0], val_ff[0][1:0]};
            `ADDR_EXT_RES_B: rd_mux = {4'h0, val_ff[5][1:0],
                val_ff[4][1:0]};
            `ADDR_EXT_RES_C: rd_mux = {6'h00, val_ff[6][1:0]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            single_channel_select_start_ff <= 1'b0;
            mux_chan_ff <= `CH_2V5;
            attenuator_bypass_all_ff <= 5'h00;
            result_valid_ff <= 1'b0;
            result_chan_ff <= `CH_2V5;
            result_code_ff <= 10'h000;
            rdata_ff <= 8'h00;
        end
        else
        begin
            single_channel_select_start_ff <= (state_ff == adc_seq_pkg::ST_START);
            mux_chan_ff <= chan_ff;
            attenuator_bypass_all_ff <= attenuator_bypass_all_next;
            result_valid_ff <= store;
            if (store)
            begin
                result_chan_ff <= chan_ff;
                result_code_ff <= acc.result;
            end
            if (i_reg_rd)
                rdata_ff <= rd_mux;
        end
    end

    assign o_single_channel_select_start = single_channel_select_start_ff;
    assign o_mux_channel = mux_chan_ff;
    assign o_attenuator_bypass_all_bypass = attenuator_bypass_all_ff;
    assign o_result_valid = result_valid_ff;
    assign o_result_channel = result_chan_ff;
    assign o_result_code = result_code_ff;
    assign o_reg_rdata = rdata_ff;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_b_ff);

    sequence s_ext_a_read;
        rd_ext_a;
    endsequence
    sequence s_group_a_locked;
        lock_ff[3:0] == 4'hF;
    endsequence
    sequence s_slot_open;
        (state_ff == adc_seq_pkg::ST_START) ##1 in_slot;
    endsequence

    AST_LOCK_SET:
        assert property (s_ext_a_read |=> s_group_a_locked)
        else $error("extended read did not lock its group");
    AST_LOCK_FREEZE:
        assert property (lock_ff[0] |=> $stable(val_ff[0]))
        else $error("locked value register changed");
    AST_LOCK_RELEASE:
        assert property (rd_val[5] |=> !lock_ff[5])
        else $error("value read did not release lock");
    AST_AVG16:
        assert property (store && !avg_off |-> single_channel_select_cnt_ff == 4'hF)
        else $error("average stored before sixteen conversions");
    AST_AVG_OFF:
        assert property (store && avg_off |=> single_channel_select_cnt_ff == 4'h0)
        else $error("single conversion not stored directly");
    AST_CYCLE:
        assert property ((state_ff == adc_seq_pkg::ST_HOLD) && !avg_off
            && !single && (nxt_state == adc_seq_pkg::ST_START)
            |-> frame_cnt_ff >= (slow_cycle ? 12'h960 : 12'h5B9))
        else $error("round-robin pass restarted early");
    AST_SLOT_LEN:
        assert property (s_slot_open |-> slot_cnt_ff ==
            ($past(chan_ff) == `CH_LOCAL ? 7'h0D :
            ($past(chan_ff) == `CH_REMOTE1 ||
            $past(chan_ff) == `CH_REMOTE2) ? 7'h46 : 7'h07))
        else $error("slot length wrong for channel");
    AST_ATTENUATOR_BYPASS_ALL:
        assert property (##1 (o_attenuator_bypass_all_bypass[2] ==
            $past(cfg2_ff[`BIT_ATTENUATOR_BYPASS_ALL_ALL])) && (o_attenuator_bypass_all_bypass[4] ==
            $past(cfg2_ff[`BIT_ATTENUATOR_BYPASS_ALL_ALL] | cfg4_ff[`BIT_BYP_12V])))
        else $error("attenuator bypass mismatch");
    AST_SINGLE:
        assert property (store && single |=> chan_ff == $past(sel_chan))
        else $error("single mode left the selected channel");
    AST_SHARE:
        assert property (i_reg_wr && hit_fan1 |=>
            sel_code == $past(i_reg_wdata[7:4]))
        else $error("select nibble not shared with fan byte");
    AST_ROUND:
        assert property (store && !single && chan_ff == `CH_LAST |=>
            (state_ff == adc_seq_pkg::ST_HOLD) && (chan_ff == `CH_2V5))
        else $error("round robin did not wrap after last channel");
    AST_START_PULSE:
        assert property (s_slot_open |-> o_single_channel_select_start ##1 !o_single_channel_select_start)
        else $error("conversion start not a single pulse");
endmodule
`default_nettype wire

/* adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Register offsets
`define ADDR_CONFIG_SIX 8'h10
`define ADDR_CURRENT_MONITOR 8'h1D
`define ADDR_TERMINATION 8'h1E
`define ADDR_EXT_RES_A 8'h1F
`define ADDR_RAIL_2V5 8'h20
`define ADDR_CORE_VOLTAGE 8'h21
`define ADDR_SUPPLY_VOLTAGE 8'h22
`define ADDR_RAIL_5V 8'h23
`define ADDR_RAIL_12V 8'h24
`define ADDR_FAN1_MIN_HIGH 8'h55
`define ADDR_CONFIG_TWO 8'h73
`define ADDR_EXT_RES_B 8'h76
`define ADDR_EXT_RES_C 8'h77
`define ADDR_CONFIG_FOUR 8'h7D

// Field positions
`define BIT_SLOW_CYCLE 7
`define BIT_AVG_DISABLE 4
`define BIT_ATTENUATOR_BYPASS_ALL_ALL 5
`define BIT_SINGLE 6
`define BIT_BYP_2V5 4
`define BIT_BYP_CORE 5
`define BIT_BYP_5V 6
`define BIT_BYP_12V 7

// Reset values
`define CFG_RESET 8'h00
`define FAN1_RESET 8'h00

// Channel codes, also the single-channel select encoding
`define CH_2V5 4'h0
`define CH_CORE 4'h1
`define CH_SUPPLY 4'h2
`define CH_5V 4'h3
`define CH_12V 4'h4
`define CH_REMOTE1 4'h5
`define CH_LOCAL 4'h6
`define CH_REMOTE2 4'h7
`define CH_TERM 4'h8
`define CH_CURRENT 4'h9
`define CH_LAST 4'h9

// Timing
`define CLK_PERIOD_NS 5
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * 1000 / `CLK_PERIOD_NS)
`define VOLT_SINGLE_CHANNEL_SELECT_US 700
`define REMOTE_SINGLE_CHANNEL_SELECT_US 7000
`define LOCAL_SINGLE_CHANNEL_SELECT_US 1300
`define CYCLE_DEFAULT_US 146500
`define CYCLE_SLOW_US 240000
`define VOLT_TICKS ((`VOLT_SINGLE_CHANNEL_SELECT_US + `TICK_US - 1) / `TICK_US)
`define REMOTE_TICKS ((`REMOTE_SINGLE_CHANNEL_SELECT_US + `TICK_US - 1) / `TICK_US)
`define LOCAL_TICKS ((`LOCAL_SINGLE_CHANNEL_SELECT_US + `TICK_US - 1) / `TICK_US)
`define CYCLE_DEFAULT_TICKS ((`CYCLE_DEFAULT_US + `TICK_US - 1) / `TICK_US)
`define CYCLE_SLOW_TICKS ((`CYCLE_SLOW_US + `TICK_US - 1) / `TICK_US)
`define AVG_COUNT 16
`define AVG_SHIFT 4

`endif

/* adc_seq_pkg.sv */
package adc_seq_pkg;
    typedef enum logic [1:0] {ST_START, ST_SLOT, ST_HOLD} seq_state_t;
    typedef logic [3:0] chan_t;
    typedef logic [9:0] code_t;
endpackage

/* accum_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface accum_if;
    logic clear;
    logic add;
    logic avg_off;
    adc_seq_pkg::code_t code;
    adc_seq_pkg::code_t result;
    modport owner (output clear, output add, output avg_off,
        output code, input result);
    modport accum (input clear, input add, input avg_off,
        input code, output result);
endinterface
`default_nettype wire

/* tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter int DIV = 20000
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Enable pulse
    output logic o_tick
);
    localparam int W = $clog2(DIV + 1);
    logic [W-1:0] cnt_ff;
    logic tick_ff;
    wire wrap = (cnt_ff == W'(DIV - 1));

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= wrap ? '0 : cnt_ff + W'(1);
            tick_ff <= wrap;
        end
    end

    assign o_tick = tick_ff;
endmodule
`default_nettype wire

/* avg_accum.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"
module avg_accum #(
    parameter int SHIFT = `AVG_SHIFT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Accumulator port
    accum_if.accum bus
);
    localparam int SW = 10 + SHIFT;
    logic [SW-1:0] sum_ff;
    logic [SW-1:0] nxt_sum;

    // Clear drops a sample landing in the same cycle; samples never
    // arrive that close to the end of a slot
    assign nxt_sum = bus.clear ? '0 :
        bus.add ? sum_ff + SW'(bus.code) : sum_ff;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sum_ff <= '0;
        else
            sum_ff <= nxt_sum;
    end

    // Sixteen 10-bit codes fit, so the mean never exceeds full scale
    assign bus.result = bus.avg_off ? sum_ff[9:0] : sum_ff[SW-1:SHIFT];
endmodule
`default_nettype wire

/* single_channel_select_model.sv */
`timescale 1ns/1ps
`default_nettype none
module single_channel_select_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Controls from the sequencer and the bench
    input wire logic i_start,
    input wire logic [9:0] i_base,
    input wire logic i_alt,
    input wire logic i_slow,
    // Sample out
    output logic o_done,
    output logic [9:0] o_code
);
    logic [4:0] wait_ff;
    logic tog_ff;
    logic [9:0] last_ff;
    logic [9:0] sample;
    // Alternating step lets an average differ from any single sample
    assign sample = (i_alt && tog_ff) ? i_base + 10'h008 : i_base;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wait_ff <= 5'h00;
            tog_ff <= 1'b0;
            last_ff <= 10'h000;
            o_done <= 1'b0;
            o_code <= 10'h3FF;
        end
        else
        begin
            o_done <= 1'b0;
            // Code lines are not valid outside the sample pulse
            o_code <= ~last_ff;
            if (i_start)
                wait_ff <= i_slow ? 5'h0C : 5'h01;
            else if (wait_ff != 5'h00)
            begin
                wait_ff <= wait_ff - 5'h01;
                if (wait_ff == 5'h01)
                begin
                    o_done <= 1'b1;
                    o_code <= sample;
                    last_ff <= sample;
                    tog_ff <= ~tog_ff;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* adc_measurement_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_measurement_sequencer_test;
    localparam int TK = 4;
    logic i_clock, i_rst_b, rd, wr, done, start, rv, alt, slow;
    logic [7:0] addr, wdata, rdata, d;
    logic [3:0] mux, rch, c;
    logic [4:0] attenuator_bypass_all;
    logic [9:0] code, base, rcode;
    int bad_count, num_checks, n;
    int tk[10] = '{7, 7, 7, 7, 7, 70, 13, 70, 7, 7};
    // Extended reads come first so the value reads after them free
    // every lock before the measurements start
    logic [7:0] ra[15] = '{8'h10, 8'h55, 8'h73, 8'h7D, 8'h1F, 8'h76,
        8'h77, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
    adc_measurement_sequencer #(.TICK_CYCLES(TK)) DUT (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_mux_channel(mux), .o_single_channel_select_start(start),
        .o_attenuator_bypass_all_bypass(attenuator_bypass_all), .i_single_channel_select_done(done), .i_single_channel_select_code(code),
        .o_result_valid(rv), .o_result_channel(rch),
        .o_result_code(rcode));
    single_channel_select_model model (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(start),
        .i_base(base), .i_alt(alt), .i_slow(slow), .o_done(done),
        .o_code(code));
    task automatic chk(input string s, input logic [15:0] e,
        input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi,
        input int v);
        num_checks++;
        if (v < lo || v > hi)
        begin
            bad_count++;
            $display("ERROR %s expected %0d to %0d seen %0d", s, lo, hi, v);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clock);
        rd <= 1'b0;
        @(posedge i_clock);
        #1;
        v = rdata;
    endtask
    task automatic wait_res(input logic [3:0] ch, output int k);
        k = 0;
        do
        begin
            @(posedge i_clock);
            #1;
            k++;
        end
        while (!(rv === 1'b1 && rch === ch) && k < 20000);
        if (k >= 20000)
        begin
            bad_count++;
            $display("ERROR result channel expected %h seen none", ch);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_regs;
        foreach (ra[i])
        begin
            reg_rd(ra[i], d);
            chk("reset value", 16'h0000, {8'h00, d});
        end
        reg_wr(8'h20, 8'hAA);
        reg_rd(8'h20, d);
        chk("read-only value", 16'h0000, {8'h00, d});
        reg_wr(8'h10, 8'h80);
        reg_rd(8'h10, d);
        chk("slow cycle bit", 16'h0080, {8'h00, d});
        reg_wr(8'h55, 8'h5A);
        reg_rd(8'h55, d);
        chk("fan1 byte", 16'h005A, {8'h00, d});
        reg_wr(8'h7D, 8'hF0);
        repeat (3) @(posedge i_clock);
        #1;
        chk("single bypass", 16'h001B, {11'h000, attenuator_bypass_all});
        reg_wr(8'h7D, 8'h00);
        reg_wr(8'h73, 8'h20);
        repeat (3) @(posedge i_clock);
        #1;
        chk("global bypass", 16'h001F, {11'h000, attenuator_bypass_all});
        reg_wr(8'h73, 8'h00);
        reg_wr(8'h55, 8'h00);
        reg_wr(8'h10, 8'h00);
        repeat (3) @(posedge i_clock);
        #1;
        chk("no bypass", 16'h0000, {11'h000, attenuator_bypass_all});
        $display("register test done");
    endtask
    task automatic t_avg;
        wait_res(4'h0, n);
        wait_res(4'h1, n);
        rng("averaged time", 16 * 6 * TK, 16 * (7 * TK + 4), n);
        chk("averaged code", 16'h0304, {6'h00, rcode});
        reg_rd(8'h1F, d);
        chk("low bits", 16'h0000, {8'h00, d});
        reg_rd(8'h21, d);
        chk("core value", 16'h00C1, {8'h00, d});
        reg_rd(8'h20, d);
        reg_rd(8'h22, d);
        reg_rd(8'h23, d);
        $display("averaging test done");
    endtask
    task automatic t_fast;
        alt <= 1'b0;
        slow <= 1'b0;
        base <= 10'h2C9;
        reg_wr(8'h73, 8'h10);
        wait_res(4'h0, n);
        for (int i = 1; i <= 10; i++)
        begin
            c = 4'(i % 10);
            wait_res(c, n);
            rng("slot time", (tk[c] - 1) * TK, tk[c] * TK + 4, n);
            chk("single code", 16'h02C9, {6'h00, rcode});
            chk("mux channel", {12'h000, c}, {12'h000, mux});
        end
        $display("unaveraged test done");
    endtask
    task automatic t_lock;
        reg_rd(8'h1F, d);
        chk("low bits", 16'h0055, {8'h00, d});
        reg_rd(8'h21, d);
        reg_rd(8'h22, d);
        reg_rd(8'h23, d);
        base <= 10'h301;
        wait_res(4'h0, n);
        reg_rd(8'h20, d);
        chk("locked value", 16'h00B2, {8'h00, d});
        wait_res(4'h0, n);
        reg_rd(8'h20, d);
        chk("released value", 16'h00C0, {8'h00, d});
        $display("lock test done");
    endtask
    task automatic t_sat;
        base <= 10'h3FF;
        wait_res(4'h9, n);
        chk("full scale", 16'h03FF, {6'h00, rcode});
        reg_rd(8'h76, d);
        chk("low bits b", 16'h000F, {8'h00, d});
        reg_rd(8'h24, d);
        chk("12 V value", 16'h00FF, {8'h00, d});
        reg_rd(8'h1E, d);
        chk("termination", 16'h00FF, {8'h00, d});
        $display("saturation test done");
    endtask
    task automatic t_single;
        reg_wr(8'h73, 8'h50);
        for (int k = 0; k <= 10; k++)
        begin
            reg_wr(8'h55, {4'(k), 4'h5});
            reg_rd(8'h55, d);
            chk("shared byte", {8'h00, 4'(k), 4'h5}, {8'h00, d});
            c = (k < 10) ? 4'(k) : 4'h0;
            wait_res(c, n);
            wait_res(c, n);
            rng("repeat time", (tk[c] - 1) * TK, tk[c] * TK + 4, n);
            chk("mux channel", {12'h000, c}, {12'h000, mux});
        end
        $display("single channel test done");
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial
    begin
        repeat (60000) @(posedge i_clock);
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        end_sim();
    end
    initial
    begin
        i_rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        base = 10'h300;
        alt = 1'b1;
        slow = 1'b1;
        bad_count = 0;
        num_checks = 0;
        repeat (6) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clock);
        t_regs();
        t_avg();
        t_fast();
        t_lock();
        t_sat();
        t_single();
        end_sim();
    end
endmodule
`default_nettype wire
